// ---- pdmo_top.sv ----
// PDM microphone data output: slot timing, sleep and wake-up
`timescale 1ns/1ps
`include "pdmo_map.svh"
module pdmo_top
  import pdmo_pkg::*;
#(
  parameter int SLEEP_CYCLES = `PDMO_SLEEP_CYCLES,
  parameter int WAKE_CYCLES = `PDMO_WAKE_CYCLES,
  parameter int FIFO_DEPTH = `PDMO_FIFO_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic pdm_clk,
  input wire logic lr_select,
  input wire logic mod_bit,
  input wire logic mod_valid,
  output logic mod_ready,
  output logic data_out,
  output logic data_oe,
  output logic awake
);

  localparam int IW = $clog2(SLEEP_CYCLES + 1);
  localparam int WW = $clog2(WAKE_CYCLES);
  localparam logic [IW-1:0] SLEEP_LAST = IW'(SLEEP_CYCLES - 1);
  localparam logic [WW-1:0] WAKE_LAST = WW'(WAKE_CYCLES - 1);

  pdmo_state_t state;
  pdmo_state_t next_state;
  logic pdm_clk_q;
  logic slot_left;
  logic [IW-1:0] idle_cnt;
  logic [WW-1:0] wake_cnt;
  logic [WW-1:0] next_wake_cnt;
  logic next_oe;
  logic fifo_valid;
  logic [0:0] fifo_data;

  // -----------------------------------------------------------------------------
  // Clock edge and slot decode
  // -----------------------------------------------------------------------------
  wire edge_rise = pdm_clk & ~pdm_clk_q;
  wire edge_fall = ~pdm_clk & pdm_clk_q;
  wire any_edge = edge_rise | edge_fall;
  wire is_active = (state == PDMO_ACTIVE);
  wire launch_edge = slot_left ? edge_fall : edge_rise;
  wire release_edge = slot_left ? edge_rise : edge_fall;
  wire idle_hit = (idle_cnt == SLEEP_LAST) & ~any_edge;
  wire launch = is_active & ~idle_hit & launch_edge;
  wire fifo_pop = launch | (~is_active & fifo_valid);
  wire next_bit = fifo_valid ? fifo_data[0] : ~data_out;
  wire wake_done = (wake_cnt == WAKE_LAST);

  assign awake = is_active;

  // -----------------------------------------------------------------------------
  // Modulator bit buffer
  // -----------------------------------------------------------------------------
  pdmo_fifo #(
    .WIDTH(`PDMO_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_valid(mod_valid),
    .in_ready(mod_ready),
    .in_data(mod_bit),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // -----------------------------------------------------------------------------
  // Sleep, wake-up and start-up sequencing
  // -----------------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    unique case (state)
      PDMO_SLEEP:
      begin
        if (edge_rise)
        begin
          next_state = PDMO_WAKING;
          next_wake_cnt = '0;
        end
      end
      PDMO_WAKING:
      begin
        if (idle_hit)
        begin
          next_state = PDMO_SLEEP;
        end
        else if (edge_rise)
        begin
          if (wake_done)
          begin
            next_state = PDMO_ACTIVE;
          end
          else
          begin
            next_wake_cnt = wake_cnt + 1'b1;
          end
        end
      end
      PDMO_ACTIVE:
      begin
        if (idle_hit)
        begin
          next_state = PDMO_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= PDMO_WAKING;
      wake_cnt <= '0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
    end
  end

  // Cycles since the last clock edge, saturating
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_cnt <= '0;
    end
    else if (clk_en)
    begin
      if (any_edge)
      begin
        idle_cnt <= '0;
      end
      else if (idle_cnt != SLEEP_LAST)
      begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------------
  // Clock sampling and slot strap
  // -----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pdm_clk_q <= 1'h0;
      slot_left <= 1'h0;
    end
    else if (clk_en)
    begin
      pdm_clk_q <= pdm_clk;
      slot_left <= lr_select;
    end
  end

  // -----------------------------------------------------------------------------
  // Data driver
  // -----------------------------------------------------------------------------
  always_comb
  begin
    next_oe = data_oe;
    if (!is_active || idle_hit)
    begin
      next_oe = 1'h0;
    end
    else if (launch)
    begin
      next_oe = 1'h1;
    end
    else if (release_edge)
    begin
      next_oe = 1'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_out <= `PDMO_RST_DATA;
      data_oe <= `PDMO_RST_OE;
    end
    else if (clk_en)
    begin
      data_oe <= next_oe;
      if (launch)
      begin
        data_out <= next_bit;
      end
    end
  end

  // -----------------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  chk_left_launch: assert property (
    clk_en && is_active && !idle_hit && slot_left && edge_fall |=> data_oe)
    else $error("left slot bit not driven after falling edge");

  chk_right_launch: assert property (
    clk_en && is_active && !idle_hit && !slot_left && edge_rise |=> data_oe)
    else $error("right slot bit not driven after rising edge");

  chk_half_release: assert property (
    clk_en && release_edge |=> !data_oe)
    else $error("driver not released in the opposite half");

  chk_slot_strap: assert property (
    clk_en && launch |-> (edge_fall == $past(lr_select)))
    else $error("launch edge does not match select strap");

  chk_stream_pass: assert property (
    clk_en && launch && fifo_valid |=> data_out == $past(fifo_data[0]))
    else $error("modulator bit not passed to the line");

  chk_zero_alternate: assert property (
    clk_en && launch && !fifo_valid |=> data_out != $past(data_out))
    else $error("idle stream does not alternate");

  chk_sleep_entry: assert property (
    clk_en && (idle_cnt == SLEEP_LAST) && !any_edge |=> state == PDMO_SLEEP && !data_oe)
    else $error("sleep not entered after clock stopped");

  chk_sleep_quiet: assert property (
    state == PDMO_SLEEP && $past(state) == PDMO_SLEEP |-> !data_oe)
    else $error("data driven while asleep");

  chk_wake_count: assert property (
    clk_en && state == PDMO_WAKING && edge_rise && !wake_done |=> state != PDMO_ACTIVE)
    else $error("woke before the full cycle count");

  chk_wake_finish: assert property (
    $rose(is_active) |-> $past(wake_cnt) == WAKE_LAST && $past(edge_rise))
    else $error("active entered without full cycle count");

  cov_wake_up: cover property ($rose(is_active));
  cov_sleep: cover property (is_active ##1 state == PDMO_SLEEP);
  cov_idle_bits: cover property (launch && !fifo_valid && clk_en);
  cov_left_launch: cover property (launch && slot_left && clk_en);

endmodule

// ---- pdmo_map.svh ----
// Constants of the PDM microphone output block
`ifndef PDMO_MAP_SVH
`define PDMO_MAP_SVH

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define PDMO_SYS_CLK_MHZ 200
`define PDMO_SLEEP_TIME_US 1000
`define PDMO_SLEEP_CYCLES (`PDMO_SLEEP_TIME_US * `PDMO_SYS_CLK_MHZ)
`define PDMO_WAKE_CYCLES 32768

// -----------------------------------------------------------------------------
// Buffer shape and reset values
// -----------------------------------------------------------------------------
`define PDMO_FIFO_DEPTH 8
`define PDMO_FIFO_WIDTH 1
`define PDMO_RST_DATA 1'h0
`define PDMO_RST_OE 1'h0

`endif

// ---- pdmo_pkg.sv ----
// Types of the PDM microphone output block
package pdmo_pkg;

  typedef enum logic [1:0] {
    PDMO_SLEEP,
    PDMO_WAKING,
    PDMO_ACTIVE
  } pdmo_state_t;

endpackage

// ---- pdmo_fifo.sv ----
// Small valid/ready FIFO for the modulator bit stream
`timescale 1ns/1ps
module pdmo_fifo
  import pdmo_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire push = in_valid & in_ready & clk_en;
  wire pop = out_valid & out_ready & clk_en;

  assign in_ready = (count != FULL_CNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // -----------------------------------------------------------------------------
  // Storage and pointers
  // -----------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ---- pdmo_host_model.sv ----
// Host codec model: bit clock source and slot capture
`timescale 1ns/1ps
module pdmo_host_model
#(
  parameter int HALF = 40
)
(
  input wire logic sys_clk,
  input wire logic run,
  input wire logic data_out,
  input wire logic data_oe,
  output logic pdm_clk,
  output logic cap_bit,
  output logic cap_lvl,
  output logic cap_valid
);
  int cnt = 0;
  initial
  begin
    pdm_clk = 1'h0;
    cap_bit = 1'h0;
    cap_lvl = 1'h0;
    cap_valid = 1'h0;
  end
  // Clock stands still while run is low; capture on the toggling edge
  always @(posedge sys_clk)
  begin
    cap_valid <= 1'h0;
    if (run)
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
      begin
        pdm_clk <= ~pdm_clk;
        cap_valid <= data_oe;
        // Released line reads as the inverse of the last bit
        cap_bit <= data_oe ? data_out : ~data_out;
        cap_lvl <= ~pdm_clk;
      end
    end
  end
endmodule

// ---- test_pdmo_top.sv ----
// Testbench for the PDM microphone output block
`timescale 1ns/1ps
module test_pdmo_top
  import pdmo_pkg::*;
;
  localparam int W = 8;
  localparam int S = 200;
  localparam int H = 40;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic run = 1'h0;
  logic lr_select = 1'h0;
  logic mod_bit = 1'h0;
  logic mod_valid = 1'h0;
  logic pdm_clk, mod_ready, data_out, data_oe, awake, cap_bit, cap_lvl, cap_valid;
  int fails = 0;
  int n_tests = 0;

  initial forever #2.5 sys_clk = ~sys_clk;

  pdmo_top #(.SLEEP_CYCLES(S), .WAKE_CYCLES(W), .FIFO_DEPTH(8)) dut_u (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(1'h1),
    .pdm_clk(pdm_clk),
    .lr_select(lr_select),
    .mod_bit(mod_bit),
    .mod_valid(mod_valid),
    .mod_ready(mod_ready),
    .data_out(data_out),
    .data_oe(data_oe),
    .awake(awake)
  );

  pdmo_host_model #(.HALF(H)) host_u (
    .sys_clk(sys_clk),
    .run(run),
    .data_out(data_out),
    .data_oe(data_oe),
    .pdm_clk(pdm_clk),
    .cap_bit(cap_bit),
    .cap_lvl(cap_lvl),
    .cap_valid(cap_valid)
  );

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  task automatic give_up(input string nm);
    $display("[ERR] %s expected event seen timeout", nm);
    fails++;
    final_report();
  endtask

  task automatic wait_cap;
    for (int i = 0; i < 4 * H; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (cap_valid === 1'h1)
        return;
    end
    give_up("capture");
  endtask

  task automatic rises_to_awake(output int n);
    logic prev;
    n = 0;
    prev = pdm_clk;
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (awake === 1'h1)
        return;
      if (pdm_clk && !prev)
        n++;
      prev = pdm_clk;
      check("oe while waking", 16'h0000, data_oe);
    end
    give_up("wake");
  endtask

  task automatic t_zero(input logic lvl);
    logic e;
    @(posedge sys_clk);
    lr_select <= lvl;
    wait_cap();
    wait_cap();
    for (int i = 0; i < 6; i++)
    begin
      e = ~cap_bit;
      wait_cap();
      check("alternating bit", e, cap_bit);
      check("capture edge", lvl, cap_lvl);
    end
  endtask

  task automatic t_fill(input logic lvl, input logic [8:0] pat);
    int taken;
    taken = 0;
    @(posedge sys_clk);
    lr_select <= lvl;
    wait_cap();
    wait_cap();
    @(posedge sys_clk);
    run <= 1'h0;
    for (int i = 0; i < 9; i++)
    begin
      @(posedge sys_clk);
      mod_valid <= 1'h1;
      mod_bit <= pat[8 - i];
      @(negedge sys_clk);
      if (mod_ready === 1'h1)
        taken++;
    end
    check("bits taken", 16'h0008, 16'(taken));
    @(posedge sys_clk);
    run <= 1'h1;
    for (int i = 0; i < 100 && mod_ready !== 1'h1; i++)
      @(negedge sys_clk);
    if (mod_ready !== 1'h1)
      give_up("ready");
    @(posedge sys_clk);
    mod_valid <= 1'h0;
    for (int i = 0; i < 9; i++)
    begin
      wait_cap();
      check("captured bit", pat[8 - i], cap_bit);
      check("capture edge", lvl, cap_lvl);
    end
  endtask

  task automatic t_sleep;
    int n;
    wait_cap();
    @(posedge sys_clk);
    run <= 1'h0;
    repeat (S - 10) @(posedge sys_clk);
    #1;
    check("awake before timeout", 16'h0001, awake);
    repeat (20) @(posedge sys_clk);
    #1;
    check("awake after timeout", 16'h0000, awake);
    check("oe in sleep", 16'h0000, data_oe);
    @(posedge sys_clk);
    run <= 1'h1;
    rises_to_awake(n);
    check("rises from sleep", 16'(W + 1), 16'(n));
  endtask

  initial
  begin
    int n;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    run <= 1'h1;
    rises_to_awake(n);
    check("rises from start", 16'(W), 16'(n));
    $display("test startup done");
    t_zero(1'h0);
    $display("test zero right done");
    t_fill(1'h0, 9'h1B4);
    $display("test fill right done");
    t_fill(1'h1, 9'h0D9);
    $display("test fill left done");
    t_sleep();
    $display("test sleep done");
    t_zero(1'h1);
    $display("test zero left done");
    final_report();
  end
endmodule
